// ===== logic/async_serial_port.sv
// Full-duplex asynchronous serial port: baud, receiver, buffers and DMA requests
//
// Overview of operation
// - Transmit and receive paths run independently and at the same time.
// - Optional ninth bit marks address characters for multidrop links.
// - Data length programmable from five to eight bits.
// - One or two stop bits sent; receiver checks the same count.
// - Parity none, even or odd; generated on transmit, checked on receive.
// - Programmed I/O: one buffered character beside each shifter.
// - DMA mode: separate transmit and receive request channels.
// - Both DMA channels default to low arbitration priority.
`timescale 1ns/1ps
`include "serial_port_consts.svh"
module async_serial_port (
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rst,
   // Configuration
   input  wire serial_port_pkg::cfg_t    cfg,
   input  wire logic [15:0]              baud_div,
   input  wire logic                     dma_prio_boost,
   // Transmit programmed I/O
   input  wire logic                     tx_wr,
   input  wire logic [8:0]               tx_data,
   output logic                          tx_full_q,
   output logic                          tx_busy_q,
   // Receive programmed I/O and status
   input  wire logic                     rx_rd,
   output logic [8:0]                    rx_data_q,
   output logic                          rx_avail_q,
   output serial_port_pkg::status_t      status_q,
   input  wire serial_port_pkg::status_t status_clr,
   // DMA channels
   output logic                          tx_dma_req_q,
   input  wire logic                     tx_dma_ack,
   output logic                          rx_dma_req_q,
   input  wire logic                     rx_dma_ack,
   output logic                          dma_prio_q,
   // Serial line
   input  wire logic                     rxd,
   output logic                          txd_q
);

   logic [15:0]                 div_cnt_q;
   logic                        rxd_m_q;
   logic                        rxd_s_q;
   logic                        rxd_p_q;
   serial_port_pkg::rx_state_t  rx_state_q;
   logic [3:0]                  ovs_q;
   logic [3:0]                  idx_q;
   logic                        stop_idx_q;
   logic                        ferr_q;
   logic [`SP_PAY_W-1:0]        bits_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Baud tick at sixteen times the bit rate
   wire [15:0] div_last = (baud_div == 16'h0000) ? 16'h0000 : 16'(baud_div - 16'h0001);
   wire        tick     = div_cnt_q >= div_last;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_cnt_q <= `SP_DIV_RST;
      end else begin
         div_cnt_q <= tick ? 16'h0000 : 16'(div_cnt_q + 16'h0001);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit path, fed by software or by the transmit DMA channel
   wire tx_load = cfg.dma_mode ? tx_dma_ack : tx_wr;

   serial_tx_path u_tx (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .cfg         (cfg),
      .tick        (tick),
      .load        (tx_load),
      .load_data   (tx_data),
      .hold_full_q (tx_full_q),
      .txd_q       (txd_q),
      .busy_q      (tx_busy_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Receive line synchroniser; edge taken from the settled stage only
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rxd_m_q <= 1'b1;
         rxd_s_q <= 1'b1;
         rxd_p_q <= 1'b1;
      end else begin
         rxd_m_q <= rxd;
         rxd_s_q <= rxd_m_q;
         rxd_p_q <= rxd_s_q;
      end
   end

   wire        fall      = rxd_p_q && !rxd_s_q;
   wire        smp       = tick && ovs_q == `SP_OVS_MID;
   wire [3:0]  n_data    = serial_port_pkg::data_bits(cfg.len);
   wire [3:0]  pay_last  = 4'(n_data + {3'h0, cfg.nine} + {3'h0, cfg.par_en} - 4'h1);
   wire        last_stop = stop_idx_q == cfg.two_stop;
   wire        rx_done   = rx_state_q == serial_port_pkg::RX_STOP && smp && last_stop;

   // Field extraction from the assembled payload
   wire [7:0]  rx_d8     = bits_q[7:0] & serial_port_pkg::data_mask(cfg.len);
   wire        rx_ninth  = cfg.nine && bits_q[n_data];
   wire        rx_pbit   = bits_q[4'(n_data + {3'h0, cfg.nine})];
   wire        par_bad   = cfg.par_en
                           && rx_pbit != serial_port_pkg::par_bit(rx_d8, cfg.par_odd);
   wire        stop_bad  = ferr_q || !rxd_s_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_state_q <= serial_port_pkg::RX_IDLE;
         ovs_q      <= 4'h0;
         idx_q      <= 4'h0;
         stop_idx_q <= 1'b0;
         ferr_q     <= 1'b0;
         bits_q     <= '0;
      end else begin
         if (tick) begin
            ovs_q <= 4'(ovs_q + 4'h1);
         end
         case (rx_state_q)
            serial_port_pkg::RX_IDLE: begin
               if (fall) begin
                  ovs_q      <= 4'h0;
                  rx_state_q <= serial_port_pkg::RX_START;
               end
            end
            serial_port_pkg::RX_START: begin
               if (smp) begin
                  idx_q      <= 4'h0;
                  bits_q     <= '0;
                  // A glitch shorter than half a bit is dropped
                  rx_state_q <= rxd_s_q ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
               end
            end
            serial_port_pkg::RX_DATA: begin
               if (smp) begin
                  bits_q[idx_q] <= rxd_s_q;
                  idx_q         <= 4'(idx_q + 4'h1);
                  stop_idx_q    <= 1'b0;
                  ferr_q        <= 1'b0;
                  if (idx_q == pay_last) begin
                     rx_state_q <= serial_port_pkg::RX_STOP;
                  end
               end
            end
            serial_port_pkg::RX_STOP: begin
               if (smp) begin
                  ferr_q     <= stop_bad;
                  stop_idx_q <= 1'b1;
                  if (last_stop) begin
                     rx_state_q <= serial_port_pkg::RX_IDLE;
                  end
               end
            end
            default: rx_state_q <= serial_port_pkg::RX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receive buffer, status and DMA requests
   wire rx_consume = rx_avail_q && (cfg.dma_mode ? rx_dma_ack : rx_rd);
   wire rx_accept  = rx_done && (!rx_avail_q || rx_consume);
   wire rx_avail_d = rx_accept || (rx_avail_q && !rx_consume);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_avail_q <= 1'b0;
         rx_data_q  <= `SP_DATA_RST;
      end else begin
         rx_avail_q <= rx_avail_d;
         if (rx_accept) begin
            rx_data_q <= {rx_ninth, rx_d8};
         end
      end
   end

   // Set wins over a clear in the same cycle; old character kept on overrun
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         status_q <= '0;
      end else begin
         status_q.overrun   <= (rx_done && !rx_accept)
                               || (status_q.overrun && !status_clr.overrun);
         status_q.frame_err <= (rx_done && stop_bad)
                               || (status_q.frame_err && !status_clr.frame_err);
         status_q.par_err   <= (rx_done && par_bad)
                               || (status_q.par_err && !status_clr.par_err);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_dma_req_q <= 1'b0;
         rx_dma_req_q <= 1'b0;
         dma_prio_q   <= 1'b0;
      end else begin
         tx_dma_req_q <= cfg.dma_mode && !tx_full_q && !tx_load;
         rx_dma_req_q <= cfg.dma_mode && rx_avail_d;
         dma_prio_q   <= cfg.dma_mode && dma_prio_boost;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_rx_avail;
      @(posedge sys_clk) disable iff (rst) rx_done && !rx_avail_q |=> rx_avail_q;
   endproperty
   a_rx_avail: assert property (p_rx_avail) else $error("Received character not buffered");

   property p_overrun;
      @(posedge sys_clk) disable iff (rst)
         rx_done && rx_avail_q && !rx_consume |=> status_q.overrun && rx_avail_q;
   endproperty
   a_overrun: assert property (p_overrun) else $error("Overrun not flagged");

   property p_par_err;
      @(posedge sys_clk) disable iff (rst) rx_done && par_bad |=> status_q.par_err;
   endproperty
   a_par_err: assert property (p_par_err) else $error("Parity error not flagged");

   property p_frame_err;
      @(posedge sys_clk) disable iff (rst)
         rx_done && !rxd_s_q |=> status_q.frame_err ##1 status_q.frame_err || $past(status_clr.frame_err);
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("Missing stop not flagged");

   property p_ninth;
      @(posedge sys_clk) disable iff (rst)
         rx_accept |=> rx_data_q[8] == $past(rx_ninth) && rx_data_q[7:0] == $past(rx_d8);
   endproperty
   a_ninth: assert property (p_ninth) else $error("Address bit or data wrong");

   property p_len;
      @(posedge sys_clk) disable iff (rst)
         rx_avail_q && !$changed(cfg.len) |-> (rx_data_q[7:0] & ~serial_port_pkg::data_mask(cfg.len)) == 8'h00;
   endproperty
   a_len: assert property (p_len) else $error("Bits beyond data length set");

   property p_dma_off;
      @(posedge sys_clk) disable iff (rst) !cfg.dma_mode |=> !tx_dma_req_q && !rx_dma_req_q;
   endproperty
   a_dma_off: assert property (p_dma_off) else $error("DMA request outside DMA mode");

   property p_prio;
      @(posedge sys_clk) disable iff (rst) !dma_prio_boost |=> !dma_prio_q;
   endproperty
   a_prio: assert property (p_prio) else $error("DMA priority raised by default");

   c_duplex: cover property (@(posedge sys_clk) disable iff (rst) tx_busy_q && rx_done);
   c_overrun: cover property (@(posedge sys_clk) disable iff (rst) rx_done && !rx_accept);
   c_dma_pair: cover property (@(posedge sys_clk) disable iff (rst) tx_dma_ack ##[1:400] rx_dma_ack);

endmodule : async_serial_port

// ===== logic/serial_port_consts.svh
// Timing counts and field constants of the asynchronous serial port
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// Oversampling: 16 baud ticks per bit
`define SP_OVS_LAST  4'hF
`define SP_OVS_MID   4'h7
// Frame vector: start + 8 data + ninth + parity + 2 stop
`define SP_FRAME_W   13
// Received payload: 8 data + ninth + parity
`define SP_PAY_W     10
// Shortest data length is five bits
`define SP_LEN_BASE  4'h5
// Reset values
`define SP_DIV_RST   16'h0000
`define SP_DATA_RST  9'h000

`endif

// ===== logic/serial_port_pkg.sv
// Types and shared helpers of the asynchronous serial port
package serial_port_pkg;

   typedef struct packed {
      logic [1:0] len;       // 0..3 selects 5..8 data bits
      logic       two_stop;
      logic       par_en;
      logic       par_odd;
      logic       nine;      // Address-detect ninth bit
      logic       dma_mode;
   } cfg_t;

   typedef struct packed {
      logic overrun;
      logic frame_err;
      logic par_err;
   } status_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } tx_state_t;

   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA  = 4'b0100,
      RX_STOP  = 4'b1000
   } rx_state_t;

   function automatic logic [3:0] data_bits(input logic [1:0] len);
      data_bits = 4'(4'h5 + {2'h0, len});
   endfunction : data_bits

   function automatic logic [7:0] data_mask(input logic [1:0] len);
      data_mask = 8'(9'h1F << len) | 8'h1F;
      data_mask = 8'hFF >> (2'h3 - len);
   endfunction : data_mask

   // Even parity makes the count of ones even
   function automatic logic par_bit(input logic [7:0] d, input logic odd);
      par_bit = (^d) ^ odd;
   endfunction : par_bit

endpackage : serial_port_pkg

// ===== logic/serial_tx_path.sv
// Transmit path: holding register, frame builder and shifter
`timescale 1ns/1ps
`include "serial_port_consts.svh"
module serial_tx_path (
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   // Configuration and baud tick
   input  wire serial_port_pkg::cfg_t cfg,
   input  wire logic                  tick,
   // Character load
   input  wire logic                  load,
   input  wire logic [8:0]            load_data,
   output logic                       hold_full_q,
   // Line
   output logic                       txd_q,
   output logic                       busy_q
);

   serial_port_pkg::tx_state_t   state_q;
   logic [8:0]                   hold_q;
   logic [`SP_FRAME_W-1:0]       frame_q;
   logic [3:0]                   left_q;
   logic [3:0]                   ovs_q;

   // Start low, data LSB first, ninth, parity, then idle-high stops
   function automatic logic [`SP_FRAME_W-1:0] build_frame(input serial_port_pkg::cfg_t c,
                                                          input logic [8:0] d);
      logic [3:0] pos;
      logic [7:0] dm;
      build_frame = '1;
      build_frame[0] = 1'b0;
      dm = d[7:0] & serial_port_pkg::data_mask(c.len);
      pos = serial_port_pkg::data_bits(c.len);
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < pos) begin
            build_frame[i + 1] = dm[i];
         end
      end
      pos = 4'(pos + 4'h1);
      if (c.nine) begin
         build_frame[pos] = d[8];
         pos = 4'(pos + 4'h1);
      end
      if (c.par_en) begin
         build_frame[pos] = serial_port_pkg::par_bit(dm, c.par_odd);
      end
   endfunction : build_frame

   wire                    start     = state_q == serial_port_pkg::TX_IDLE && hold_full_q;
   wire                    bit_end   = tick && ovs_q == `SP_OVS_LAST;
   wire [`SP_FRAME_W-1:0]  frame_new = build_frame(cfg, hold_q);
   // Start + data + ninth + parity + stops; counts every bit that leaves the shifter
   wire [3:0]              frame_n   = 4'(4'h7 + {2'h0, cfg.len} + {3'h0, cfg.nine}
                                          + {3'h0, cfg.par_en} + {3'h0, cfg.two_stop});
   wire [3:0]              stop_n    = cfg.two_stop ? 4'h2 : 4'h1;

   // One-hot send bit, straight from the state flop
   assign busy_q = state_q[1];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hold_q      <= `SP_DATA_RST;
         hold_full_q <= 1'b0;
      end else begin
         if (load && !hold_full_q) begin
            hold_q <= load_data;
         end
         // A load while full is dropped, so stale data is never resent
         hold_full_q <= (hold_full_q && !start) || (load && !hold_full_q);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= serial_port_pkg::TX_IDLE;
         frame_q <= '1;
         left_q  <= 4'h0;
         ovs_q   <= 4'h0;
         txd_q   <= 1'b1;
      end else begin
         case (state_q)
            serial_port_pkg::TX_IDLE: begin
               txd_q <= 1'b1;
               if (start) begin
                  frame_q <= frame_new;
                  left_q  <= frame_n;
                  ovs_q   <= 4'h0;
                  txd_q   <= frame_new[0];
                  state_q <= serial_port_pkg::TX_SEND;
               end
            end
            serial_port_pkg::TX_SEND: begin
               if (tick) begin
                  ovs_q <= 4'(ovs_q + 4'h1);
               end
               if (bit_end) begin
                  if (left_q == 4'h1) begin
                     txd_q   <= 1'b1;
                     state_q <= serial_port_pkg::TX_IDLE;
                  end else begin
                     frame_q <= {1'b1, frame_q[`SP_FRAME_W-1:1]};
                     txd_q   <= frame_q[1];
                     left_q  <= 4'(left_q - 4'h1);
                  end
               end
            end
            default: state_q <= serial_port_pkg::TX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_idle_high;
      @(posedge sys_clk) disable iff (rst) !busy_q |-> txd_q;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("Line not high while idle");

   property p_start_low;
      @(posedge sys_clk) disable iff (rst) start |=> busy_q && !txd_q;
   endproperty
   a_start_low: assert property (p_start_low) else $error("Start bit not low");

   property p_hold_load;
      @(posedge sys_clk) disable iff (rst) load && !hold_full_q |=> hold_full_q;
   endproperty
   a_hold_load: assert property (p_hold_load) else $error("Holding register not filled");

   property p_stop_high;
      @(posedge sys_clk) disable iff (rst) busy_q && left_q <= stop_n |-> txd_q;
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("Stop bit not high");

endmodule : serial_tx_path

// ===== verif/remote_uart_model.sv
// Remote serial peer: builds frames onto rxd and decodes frames from txd
`timescale 1ns/1ps
module remote_uart_model (
   // Clock
   input  wire logic sys_clk,
   // Line
   input  wire logic txd,
   output logic      rxd
);
   // Bit time fixed at 16 cycles, matching a divisor of one
   initial rxd = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   task automatic put_char(input serial_port_pkg::cfg_t c, input logic [8:0] d,
                           input logic bad_par, input logic bad_stop);
      logic [12:0] fr;
      int          n;
      fr = '1;
      fr[0] = 1'b0;
      n = 1;
      for (int i = 0; i < 5 + c.len; i++) begin
         fr[n] = d[i];
         n++;
      end
      if (c.nine) begin
         fr[n] = d[8];
         n++;
      end
      if (c.par_en) begin
         fr[n] = ^(d[7:0] & (8'hFF >> (2'h3 - c.len))) ^ c.par_odd ^ bad_par;
         n++;
      end
      fr[n] = ~bad_stop;
      n = n + 1 + c.two_stop;
      for (int i = 0; i < n; i++) begin
         rxd = fr[i];
         repeat (16) @(negedge sys_clk);
      end
      // Mark level for one bit time, so a following start makes a fresh falling edge
      rxd = 1'b1;
      repeat (16) @(negedge sys_clk);
   endtask : put_char

   ////////////////////////////////////////////////////////////////////////////
   task automatic get_char(input serial_port_pkg::cfg_t c, output logic [8:0] d,
                           output logic par_ok, output logic stop_ok, output logic seen);
      d = '0;
      par_ok = 1'b1;
      stop_ok = 1'b1;
      seen = 1'b0;
      for (int k = 0; k < 20000 && txd !== 1'b0; k++) @(negedge sys_clk);
      if (txd !== 1'b0) return;
      seen = 1'b1;
      repeat (8) @(negedge sys_clk);
      stop_ok = (txd === 1'b0);
      for (int i = 0; i < 5 + c.len; i++) begin
         repeat (16) @(negedge sys_clk);
         d[i] = txd;
      end
      if (c.nine) begin
         repeat (16) @(negedge sys_clk);
         d[8] = txd;
      end
      if (c.par_en) begin
         repeat (16) @(negedge sys_clk);
         par_ok = (txd === (^d[7:0] ^ c.par_odd));
      end
      for (int i = 0; i < 1 + c.two_stop; i++) begin
         repeat (16) @(negedge sys_clk);
         stop_ok = stop_ok & (txd === 1'b1);
      end
   endtask : get_char
endmodule : remote_uart_model

// ===== verif/tb_async_serial_port.sv
// Self-checking testbench of the asynchronous serial port
`timescale 1ns/1ps
module tb_async_serial_port;
   logic                     sys_clk = 1'b0;
   logic                     rst = 1'b1;
   serial_port_pkg::cfg_t    cfg;
   logic [15:0]              baud_div;
   logic                     dma_prio_boost, tx_wr, rx_rd, tx_dma_ack, rx_dma_ack;
   logic [8:0]               tx_data, rx_data_q;
   logic                     tx_full_q, tx_busy_q, rx_avail_q, tx_dma_req_q, rx_dma_req_q;
   logic                     dma_prio_q, rxd, txd_q;
   serial_port_pkg::status_t status_q, status_clr;
   int                       checked = 0;
   int                       miscompares = 0;

   async_serial_port dut (.sys_clk(sys_clk), .rst(rst), .cfg(cfg), .baud_div(baud_div),
      .dma_prio_boost(dma_prio_boost), .tx_wr(tx_wr), .tx_data(tx_data),
      .tx_full_q(tx_full_q), .tx_busy_q(tx_busy_q), .rx_rd(rx_rd), .rx_data_q(rx_data_q),
      .rx_avail_q(rx_avail_q), .status_q(status_q), .status_clr(status_clr),
      .tx_dma_req_q(tx_dma_req_q), .tx_dma_ack(tx_dma_ack), .rx_dma_req_q(rx_dma_req_q),
      .rx_dma_ack(rx_dma_ack), .dma_prio_q(dma_prio_q), .rxd(rxd), .txd_q(txd_q));
   remote_uart_model peer (.sys_clk(sys_clk), .txd(txd_q), .rxd(rxd));

   always #2.5 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("Comparisons made: %0d, mismatches: %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   // Strobes rise and fall on falling edges, one cycle wide
   task automatic pulse(input int sel);
      @(negedge sys_clk);
      {rx_dma_ack, tx_dma_ack, rx_rd, tx_wr} = 4'(1 << sel);
      @(negedge sys_clk);
      {rx_dma_ack, tx_dma_ack, rx_rd, tx_wr} = 4'h0;
   endtask : pulse

   task automatic wait_sig(input int sel, input logic lvl);
      logic v;
      for (int k = 0; k < 5000; k++) begin
         v = (sel == 0) ? tx_busy_q : (sel == 1) ? rx_avail_q :
             (sel == 2) ? rx_dma_req_q : tx_dma_req_q;
         if (v === lvl) return;
         @(negedge sys_clk);
      end
      $display("CHECK FAILED wait on %0d: expected %b, seen %b", sel, lvl, v);
      miscompares++;
      tally_and_finish();
   endtask : wait_sig

   task automatic clear_status();
      @(negedge sys_clk);
      status_clr = 3'h7;
      @(negedge sys_clk);
      status_clr = 3'h0;
   endtask : clear_status

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("txd idle", 9'h001, 9'(txd_q));
      chk("outputs idle", 9'h000, 9'({tx_full_q, tx_busy_q, rx_avail_q, status_q,
          tx_dma_req_q, rx_dma_req_q, dma_prio_q}));
      $display("Test reset done");
   endtask : t_reset

   // Both directions at once in four formats, one for each data length
   task automatic t_formats();
      serial_port_pkg::cfg_t tbl [4];
      logic [8:0]            dat [4];
      logic [8:0]            got, exp;
      logic                  pok, sok, seen;
      int                    cnt, nb;
      tbl = '{7'h00, 7'h38, 7'h4E, 7'h7A};
      dat = '{9'h0B5, 9'h1CA, 9'h153, 9'h16E};
      for (int i = 0; i < 4; i++) begin
         cfg = tbl[i];
         nb = 7 + tbl[i].len + tbl[i].nine + tbl[i].par_en + tbl[i].two_stop;
         exp = {tbl[i].nine & dat[i][8], dat[i][7:0] & (8'hFF >> (2'h3 - tbl[i].len))};
         cnt = 0;
         fork
            peer.put_char(tbl[i], ~dat[i], 1'b0, 1'b0);
            peer.get_char(tbl[i], got, pok, sok, seen);
            begin
               tx_data = dat[i];
               pulse(0);
               wait_sig(0, 1'b1);
               while (tx_busy_q === 1'b1 && cnt < 400) begin
                  @(negedge sys_clk);
                  cnt++;
               end
            end
         join
         chk("tx frame seen", 9'h001, 9'(seen));
         chk("tx data", exp, got);
         chk("tx parity and stop", 9'h003, {7'h0, pok, sok});
         chk("tx frame cycles", 9'(nb * 16), 9'(cnt));
         wait_sig(1, 1'b1);
         chk("rx data", {tbl[i].nine & ~dat[i][8],
             ~dat[i][7:0] & (8'hFF >> (2'h3 - tbl[i].len))}, rx_data_q);
         chk("rx status clean", 9'h000, 9'(status_q));
         pulse(1);
         chk("rx popped", 9'h000, 9'(rx_avail_q));
      end
      $display("Test formats done");
   endtask : t_formats

   task automatic t_back_to_back();
      logic [8:0] g1, g2;
      logic       pok, sok, seen;
      cfg = 7'h60;
      fork
         begin
            peer.get_char(7'h60, g1, pok, sok, seen);
            peer.get_char(7'h60, g2, pok, sok, seen);
         end
         begin
            tx_data = 9'h03C;
            pulse(0);
            wait_sig(0, 1'b1);
            tx_data = 9'h0C3;
            pulse(0);
            chk("holding full", 9'h001, 9'(tx_full_q));
            tx_data = 9'h0FF;
            pulse(0);
         end
      join
      chk("first char", 9'h03C, g1);
      chk("second char", 9'h0C3, g2);
      repeat (40) @(negedge sys_clk);
      chk("third dropped", 9'h001, {7'h0, tx_busy_q, txd_q});
      $display("Test back to back done");
   endtask : t_back_to_back

   task automatic t_rx_errors();
      cfg = 7'h68;
      peer.put_char(7'h68, 9'h055, 1'b1, 1'b0);
      wait_sig(1, 1'b1);
      chk("parity error", 9'h001, 9'(status_q));
      pulse(1);
      clear_status();
      chk("status cleared", 9'h000, 9'(status_q));
      peer.put_char(7'h68, 9'h0AA, 1'b0, 1'b1);
      wait_sig(1, 1'b1);
      chk("frame error", 9'h002, 9'(status_q));
      peer.put_char(7'h68, 9'h011, 1'b0, 1'b0);
      repeat (4) @(negedge sys_clk);
      chk("overrun sticky", 9'h006, 9'(status_q));
      chk("old char kept", 9'h0AA, rx_data_q);
      pulse(1);
      clear_status();
      chk("all clear", 9'h000, {5'h0, rx_avail_q, status_q});
      $display("Test receive errors done");
   endtask : t_rx_errors

   task automatic t_dma();
      logic [8:0] g;
      logic       pok, sok, seen;
      cfg = 7'h61;
      wait_sig(3, 1'b1);
      chk("default priority", 9'h000, 9'(dma_prio_q));
      fork
         peer.get_char(7'h61, g, pok, sok, seen);
         begin
            tx_data = 9'h05A;
            pulse(2);
         end
      join
      chk("dma tx char", 9'h05A, g);
      peer.put_char(7'h61, 9'h0E7, 1'b0, 1'b0);
      wait_sig(2, 1'b1);
      chk("dma rx char", 9'h0E7, rx_data_q);
      pulse(3);
      @(negedge sys_clk);
      chk("dma rx taken", 9'h000, 9'(rx_dma_req_q));
      dma_prio_boost = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk("raised priority", 9'h001, 9'(dma_prio_q));
      cfg = 7'h60;
      repeat (2) @(negedge sys_clk);
      chk("pio drops dma", 9'h000, {6'h0, dma_prio_q, tx_dma_req_q, rx_dma_req_q});
      $display("Test dma done");
   endtask : t_dma

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cfg = '0;
      baud_div = 16'h0001;
      dma_prio_boost = 1'b0;
      {tx_wr, rx_rd, tx_dma_ack, rx_dma_ack} = 4'h0;
      tx_data = 9'h000;
      status_clr = 3'h0;
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      t_reset();
      t_formats();
      t_back_to_back();
      t_rx_errors();
      t_dma();
      tally_and_finish();
   end
endmodule : tb_async_serial_port
